// [src/pmbus_status_telemetry_regs.sv]
// Status and telemetry register bank with peak tracking and command read port
`timescale 1ns/1ns
module pmbus_status_telemetry_regs
	import telemetry_regs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Command port from the serial engine
	input wire logic cmd_read,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic page,
	input wire logic clear_maxima_cmd,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic rd_unsupported,
	output logic wr_refused,
	// Measurement sample from the converter, same clock
	input wire logic meas_valid,
	input wire logic [10:0] vin_mant,
	input wire logic [1:0][15:0] vout_mant,
	input wire logic [4:0] vout_exp,
	input wire logic [1:0][11:0] current_sense_inputs,
	input wire logic [1:0][11:0] diode_raw,
	input wire logic [10:0] die_temp_mant,
	input wire logic [1:0][9:0] duty_frac,
	// Calibration settings, same clock
	input wire logic [1:0][15:0] current_sense_gain,
	input wire logic [1:0][11:0] sense_gain_tempco,
	input wire logic [1:0][15:0] ext_temp_gain,
	input wire logic [1:0][10:0] ext_temp_offset,
	input wire logic [1:0][10:0] input_current_offset,
	// Internal status levels, same clock
	input wire logic supply_3v3_ov,
	input wire logic supply_3v3_uv,
	input wire logic adc_invalid,
	input wire logic alert_drive_low,
	input wire logic chan1_pgood,
	input wire logic chan0_pgood,
	input wire logic [1:0] run_drive_low,
	input wire logic [1:0] gp_drive_low,
	input wire logic busy,
	input wire logic calc_pending,
	input wire logic in_transition,
	input wire logic nvm_initialized,
	// Memory correction status and refresh events, same clock
	input wire logic ecc_corrected,
	input wire logic restore_done,
	input wire logic reset_cmd_done,
	input wire logic bulk_read_done,
	// Pins from outside the clock domain
	input wire logic chan1_run_pin,
	input wire logic chan0_run_pin,
	input wire logic gp_pin1,
	input wire logic gp_pin0,
	input wire logic write_protect_pin,
	input wire logic shared_sync_clock
);
	import telemetry_regs_pkg::*;

	typedef struct packed {
		logic [1:0] run_s1;
		logic [1:0] run_s2;
		logic [1:0] gp_s1;
		logic [1:0] gp_s2;
		logic wp_s1;
		logic wp_s2;
		logic shclk_s1;
		logic shclk_s2;
		logic shclk_d;
		logic [SHARE_CNT_W-1:0] share_cnt;
		logic share_timeout;
		logic ecc_ok;
		logic por_pending;
		logic [10:0] vin;
		logic [10:0] tint;
		logic [10:0] iin_tot;
		logic [10:0] vin_max;
		logic [10:0] tint_max;
		logic [1:0][15:0] vout;
		logic [1:0][15:0] vout_max;
		logic [1:0][10:0] iout;
		logic [1:0][10:0] text;
		logic [1:0][10:0] duty;
		logic [1:0][10:0] pout;
		logic [1:0][10:0] iin_ch;
		logic [1:0][10:0] iout_max;
		logic [1:0][10:0] text_max;
		logic [15:0] rd_data;
		logic rd_valid;
		logic rd_unsupported;
		logic wr_refused;
	} state_t;

	state_t st;
	state_t next_st;

	// Clamp a wide signed value into an 11-bit mantissa
	function automatic logic [10:0] sat11(input logic signed [31:0] v);
		if (v > 32'sd1023) begin
			return 11'h3FF;
		end
		if (v < -32'sd1024) begin
			return 11'h400;
		end
		return v[10:0];
	endfunction : sat11

	// Signed greater-than on 11-bit mantissas
	function automatic logic gt11(input logic [10:0] a, input logic [10:0] b);
		return $signed(a) > $signed(b);
	endfunction : gt11

	logic [15:0] pin_word;
	logic [7:0] status_byte;
	logic [15:0] info_word;

	// Live status words, reserved bits tied to zero
	assign pin_word = {supply_3v3_ov, supply_3v3_uv, 2'b00, adc_invalid, alert_drive_low,
		chan1_pgood, chan0_pgood, run_drive_low, st.run_s2, gp_drive_low, st.gp_s2};
	assign status_byte = {~alert_drive_low, ~busy, ~calc_pending, ~in_transition,
		nvm_initialized, 1'b0, st.share_timeout, st.wp_s2};
	assign info_word = {10'h000, st.ecc_ok, 5'h00};

	// Next-state logic: sync, timeout, refresh, telemetry math, maxima, read port
	always_comb begin
		logic signed [31:0] t_temp;
		logic signed [31:0] t_gain;
		logic signed [31:0] t_iout;
		logic signed [31:0] t_iin;
		logic signed [31:0] t_pow;
		logic signed [31:0] t_shift;
		logic [10:0] cur_iout;
		logic ch;
		t_temp = '0;
		t_gain = '0;
		t_iout = '0;
		t_iin = '0;
		t_pow = '0;
		t_shift = '0;
		cur_iout = '0;
		ch = page;
		next_st = st;
		// Two-flop synchronisers; only the second stage is read
		next_st.run_s1 = {chan1_run_pin, chan0_run_pin};
		next_st.run_s2 = st.run_s1;
		next_st.gp_s1 = {gp_pin1, gp_pin0};
		next_st.gp_s2 = st.gp_s1;
		next_st.wp_s1 = write_protect_pin;
		next_st.wp_s2 = st.wp_s1;
		next_st.shclk_s1 = shared_sync_clock;
		next_st.shclk_s2 = st.shclk_s1;
		next_st.shclk_d = st.shclk_s2;
		// Shared clock timeout: any edge restarts the count
		if (st.shclk_s2 != st.shclk_d) begin
			next_st.share_cnt = '0;
			next_st.share_timeout = 1'b0;
		end else if (st.share_cnt == SHARE_CNT_W'(SHARE_TIMEOUT_CYC)) begin
			next_st.share_timeout = 1'b1;
		end else begin
			next_st.share_cnt = st.share_cnt + 1'b1;
		end
		// Correction flag refresh; power-on handled one cycle after release
		if (st.por_pending || restore_done || reset_cmd_done || bulk_read_done) begin
			next_st.ecc_ok = ~ecc_corrected;
		end
		next_st.por_pending = 1'b0;
		// Peaks clear first so a same-cycle sample still lands
		if (clear_maxima_cmd) begin
			next_st.vin_max = MANT_MIN;
			next_st.tint_max = MANT_MIN;
			next_st.vout_max = {2{VOUT_MAX_RESET}};
			next_st.iout_max = {2{MANT_MIN}};
			next_st.text_max = {2{MANT_MIN}};
		end
		if (meas_valid) begin
			next_st.vin = vin_mant;
			next_st.tint = die_temp_mant;
			if (gt11(vin_mant, next_st.vin_max)) begin
				next_st.vin_max = vin_mant;
			end
			if (gt11(die_temp_mant, next_st.tint_max)) begin
				next_st.tint_max = die_temp_mant;
			end
			for (int c = 0; c < 2; c++) begin
				// External temperature from diode, gain Q8 plus offset
				t_temp = (32'($signed(diode_raw[c])) * $signed({16'h0000, ext_temp_gain[c]}))
					>>> 8;
				t_temp = t_temp + 32'($signed(ext_temp_offset[c]));
				next_st.text[c] = sat11(t_temp);
				// Sense gain corrected by tempco against that temperature
				t_gain = 32'($signed(sense_gain_tempco[c]))
					* (32'($signed(next_st.text[c])) - 32'($signed(TEMP_REF_MANT)));
				t_gain = $signed({16'h0000, current_sense_gain[c]}) + (t_gain >>> 10);
				t_iout = (32'($signed(current_sense_inputs[c])) * t_gain) >>> 8;
				cur_iout = sat11(t_iout);
				next_st.iout[c] = cur_iout;
				// Duty in percent at 0.25 %: frac*400/1024
				next_st.duty[c] = 11'((32'(duty_frac[c]) * 32'sd25) >>> 6);
				t_iin = (32'($signed(cur_iout)) * $signed({22'h000000, duty_frac[c]})) >>> 10;
				next_st.iin_ch[c] = sat11(t_iin + 32'($signed(input_current_offset[c])));
				// Power from this sample's voltage and current pair
				t_pow = $signed({16'h0000, vout_mant[c]}) * 32'($signed(cur_iout));
				t_shift = 32'sd2 - 32'($signed(vout_exp));
				if (t_shift < 0) begin
					t_shift = 0;
				end
				next_st.pout[c] = sat11(t_pow >>> t_shift);
				next_st.vout[c] = vout_mant[c];
				if (vout_mant[c] > next_st.vout_max[c]) begin
					next_st.vout_max[c] = vout_mant[c];
				end
				if (gt11(cur_iout, next_st.iout_max[c])) begin
					next_st.iout_max[c] = cur_iout;
				end
				if (gt11(next_st.text[c], next_st.text_max[c])) begin
					next_st.text_max[c] = next_st.text[c];
				end
			end
			t_iin = 32'($signed(next_st.iin_ch[0])) + 32'($signed(next_st.iin_ch[1]));
			next_st.iin_tot = sat11(t_iin);
		end
		// Read port answers one cycle after the strobe
		next_st.rd_valid = cmd_read;
		next_st.rd_unsupported = 1'b0;
		next_st.wr_refused = cmd_write;
		next_st.rd_data = 16'h0000;
		if (cmd_read) begin
			unique case (cmd_code)
				CODE_INPUT_VOLTAGE_READING: next_st.rd_data = {VIN_EXP, st.vin};
				CODE_INPUT_CURRENT_TOTAL: next_st.rd_data = {CURRENT_EXP, st.iin_tot};
				CODE_OUTPUT_VOLTAGE_READING: next_st.rd_data = st.vout[ch];
				CODE_OUTPUT_CURRENT_READING: next_st.rd_data = {CURRENT_EXP, st.iout[ch]};
				CODE_EXTERNAL_TEMP_READING: next_st.rd_data = {TEMP_EXP, st.text[ch]};
				CODE_INTERNAL_TEMP_READING: next_st.rd_data = {TEMP_EXP, st.tint};
				CODE_DUTY_CYCLE_READING: next_st.rd_data = {DUTY_EXP, st.duty[ch]};
				CODE_OUTPUT_POWER_READING: next_st.rd_data = {POWER_EXP, st.pout[ch]};
				CODE_OUTPUT_CURRENT_MAX: next_st.rd_data = {CURRENT_EXP, st.iout_max[ch]};
				CODE_OUTPUT_VOLTAGE_MAX: next_st.rd_data = st.vout_max[ch];
				CODE_INPUT_VOLTAGE_MAX: next_st.rd_data = {VIN_EXP, st.vin_max};
				CODE_EXTERNAL_TEMP_MAX: next_st.rd_data = {TEMP_EXP, st.text_max[ch]};
				CODE_CHANNEL_INPUT_CURRENT: next_st.rd_data = {CURRENT_EXP, st.iin_ch[ch]};
				CODE_INTERNAL_TEMP_MAX: next_st.rd_data = {TEMP_EXP, st.tint_max};
				CODE_PIN_STATE_WORD: next_st.rd_data = pin_word;
				CODE_SHARED_STATUS_BYTE: next_st.rd_data = {8'h00, status_byte};
				CODE_ECC_INFO_WORD: next_st.rd_data = info_word;
				default: next_st.rd_unsupported = 1'b1;
			endcase
		end
	end

	// State register; maxima start at their floor so the first sample wins
	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.por_pending <= 1'b1;
			st.ecc_ok <= ECC_INFO_RESET;
			st.vin_max <= MANT_MIN;
			st.tint_max <= MANT_MIN;
			st.vout_max <= {2{VOUT_MAX_RESET}};
			st.iout_max <= {2{MANT_MIN}};
			st.text_max <= {2{MANT_MIN}};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign rd_data = st.rd_data;
	assign rd_valid = st.rd_valid;
	assign rd_unsupported = st.rd_unsupported;
	assign wr_refused = st.wr_refused;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_read_pin;
		cmd_read && cmd_code == CODE_PIN_STATE_WORD;
	endsequence
	sequence s_vin_rise;
		meas_valid && !clear_maxima_cmd && gt11(vin_mant, st.vin_max);
	endsequence

	a_read_answer: assert property (cmd_read |=> rd_valid ##1 !rd_valid || $past(cmd_read))
		else $error("read strobe got no single answer");
	a_pin_reserved: assert property (s_read_pin |=> rd_data[13:12] == 2'b00
		&& rd_data[PIN_ALERT_DRIVE_BIT] == $past(alert_drive_low))
		else $error("pin word reserved or alert bit wrong");
	a_pin_supply: assert property (s_read_pin |=> rd_data[PIN_SUPPLY_OV_BIT] == $past(supply_3v3_ov)
		&& rd_data[PIN_ADC_INVALID_BIT] == $past(adc_invalid))
		else $error("pin word supply bits wrong");
	a_status_busy: assert property (cmd_read && cmd_code == CODE_SHARED_STATUS_BYTE
		|=> rd_data[6] == !$past(busy) && rd_data[15:8] == 8'h00)
		else $error("status byte busy bit wrong");
	a_ecc_refresh: assert property (restore_done |=> st.ecc_ok == !$past(ecc_corrected))
		else $error("correction flag not refreshed");
	a_vin_peak: assert property (s_vin_rise |=> st.vin_max == $past(vin_mant) ##1
		($past(clear_maxima_cmd) || $signed(st.vin_max) >= $signed($past(st.vin_max))))
		else $error("input voltage maximum not tracking");
	a_peak_clear: assert property (clear_maxima_cmd && !meas_valid |=> st.vin_max == MANT_MIN
		&& st.tint_max == MANT_MIN)
		else $error("clear did not reset maxima");
	a_write_ignored: assert property (cmd_write && !meas_valid && !clear_maxima_cmd
		|=> wr_refused && $stable(st.vin_max) && $stable(st.vout))
		else $error("write disturbed stored values");
	a_share_edge: assert property ($changed(st.shclk_s2) |=> ##1 !st.share_timeout)
		else $error("shared clock edge left timeout set");
	a_iin_sum: assert property (meas_valid |=> $signed(st.iin_tot)
		== $signed(sat11(32'($signed(st.iin_ch[0])) + 32'($signed(st.iin_ch[1])))))
		else $error("total input current not the channel sum");
endmodule : pmbus_status_telemetry_regs

// [src/telemetry_regs_pkg.sv]
// Command codes, field layout, exponents and timing for the status and telemetry bank
package telemetry_regs_pkg;
	// Telemetry and maxima command codes
	localparam logic [7:0] CODE_INPUT_VOLTAGE_READING = 8'h88;
	localparam logic [7:0] CODE_INPUT_CURRENT_TOTAL = 8'h89;
	localparam logic [7:0] CODE_OUTPUT_VOLTAGE_READING = 8'h8B;
	localparam logic [7:0] CODE_OUTPUT_CURRENT_READING = 8'h8C;
	localparam logic [7:0] CODE_EXTERNAL_TEMP_READING = 8'h8D;
	localparam logic [7:0] CODE_INTERNAL_TEMP_READING = 8'h8E;
	localparam logic [7:0] CODE_DUTY_CYCLE_READING = 8'h94;
	localparam logic [7:0] CODE_OUTPUT_POWER_READING = 8'h96;
	localparam logic [7:0] CODE_OUTPUT_CURRENT_MAX = 8'hD7;
	localparam logic [7:0] CODE_OUTPUT_VOLTAGE_MAX = 8'hDD;
	localparam logic [7:0] CODE_INPUT_VOLTAGE_MAX = 8'hDE;
	localparam logic [7:0] CODE_EXTERNAL_TEMP_MAX = 8'hDF;
	localparam logic [7:0] CODE_CHANNEL_INPUT_CURRENT = 8'hED;
	localparam logic [7:0] CODE_INTERNAL_TEMP_MAX = 8'hF4;
	// Status words without a printed code
	localparam logic [7:0] CODE_PIN_STATE_WORD = 8'hE5;
	localparam logic [7:0] CODE_SHARED_STATUS_BYTE = 8'hE6;
	localparam logic [7:0] CODE_ECC_INFO_WORD = 8'hE7;
	// Bit positions
	localparam int PIN_SUPPLY_OV_BIT = 15;
	localparam int PIN_SUPPLY_UV_BIT = 14;
	localparam int PIN_ADC_INVALID_BIT = 11;
	localparam int PIN_ALERT_DRIVE_BIT = 10;
	localparam int ECC_NO_CORRECTION_BIT = 5;
	// Linear exponents (5-bit two's complement)
	localparam logic [4:0] VIN_EXP = 5'h1B;
	localparam logic [4:0] CURRENT_EXP = 5'h1C;
	localparam logic [4:0] TEMP_EXP = 5'h1E;
	localparam logic [4:0] DUTY_EXP = 5'h1E;
	localparam logic [4:0] POWER_EXP = 5'h1E;
	// Reset values
	localparam logic [10:0] MANT_MIN = 11'h400;
	localparam logic [15:0] VOUT_MAX_RESET = 16'h0000;
	localparam logic ECC_INFO_RESET = 1'b1;
	// Gain-compensation reference temperature, 25 C at 0.25 C per count
	localparam logic [10:0] TEMP_REF_MANT = 11'h064;
	// Shared-clock timeout
	localparam int CLOCK_MHZ = 25;
	localparam int SHARE_TIMEOUT_US = 64;
	localparam int SHARE_TIMEOUT_CYC = SHARE_TIMEOUT_US * CLOCK_MHZ;
	localparam int SHARE_CNT_W = 11;
endpackage : telemetry_regs_pkg

// [dv/telemetry_host_model.sv]
// Host controller model issuing word reads, refused writes and clear-peaks pulses
`timescale 1ns/1ns
module telemetry_host_model (
	// Clock
	input wire logic clock,
	// Command port toward the bank
	output logic cmd_read,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic page,
	output logic clear_maxima_cmd,
	// Answers from the bank
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_unsupported,
	input wire logic wr_refused
);
	// Idle state; a released code shows its inverse so a stale code never looks held
	initial begin
		cmd_read = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		page = 1'b0;
		clear_maxima_cmd = 1'b0;
	end

	// One-cycle read request; the answer stands only in the cycle after the
	// taking edge, so it is captured there before the request is released
	task read_word(input logic [7:0] code, input logic pg, output logic [15:0] data,
		output logic valid, output logic unsup);
		@(posedge clock) #1;
		cmd_read = 1'b1;
		cmd_code = code;
		page = pg;
		@(posedge clock) #1;
		data = rd_data;
		valid = rd_valid;
		unsup = rd_unsupported;
		cmd_read = 1'b0;
		cmd_code = ~code;
		page = ~pg;
	endtask : read_word

	// Write attempt to a read-only code
	task write_word(input logic [7:0] code, output logic refused);
		@(posedge clock) #1;
		cmd_write = 1'b1;
		cmd_code = code;
		@(posedge clock) #1;
		refused = wr_refused;
		cmd_write = 1'b0;
		cmd_code = ~code;
	endtask : write_word

	// Clear-peaks pulse
	task pulse_clear();
		@(posedge clock) #1;
		clear_maxima_cmd = 1'b1;
		@(posedge clock) #1;
		clear_maxima_cmd = 1'b0;
	endtask : pulse_clear
endmodule : telemetry_host_model

// [dv/pmbus_status_telemetry_regs_tb_top.sv]
// Self-checking bench for the status and telemetry register bank
`timescale 1ns/1ns
module pmbus_status_telemetry_regs_tb_top
	import telemetry_regs_pkg::*;
;
	typedef struct packed {logic [17:0] lv; logic [7:0] code; logic pg; logic [15:0] exp;} row_t;
	logic clock, rst, cmd_read, cmd_write, page, clear_maxima_cmd;
	logic rd_valid, rd_unsupported, wr_refused, meas_valid, share_run, d, v, u, r;
	logic [7:0] cmd_code;
	logic [15:0] rd_data, dw;
	logic [10:0] vin_mant, die_temp_mant;
	logic [1:0][15:0] vout_mant, current_sense_gain, ext_temp_gain;
	logic [4:0] vout_exp;
	logic [1:0][11:0] current_sense_inputs, diode_raw, sense_gain_tempco;
	logic [1:0][9:0] duty_frac;
	logic [1:0][10:0] ext_temp_offset, input_current_offset;
	logic supply_3v3_ov, supply_3v3_uv, adc_invalid, alert_drive_low, chan1_pgood, chan0_pgood;
	logic [1:0] run_drive_low, gp_drive_low;
	logic busy, calc_pending, in_transition, nvm_initialized, ecc_corrected;
	logic restore_done, reset_cmd_done, bulk_read_done;
	logic chan1_run_pin, chan0_run_pin, gp_pin1, gp_pin0, write_protect_pin, shared_sync_clock;
	logic [17:0] lv;
	logic [2:0] ev;
	int checks = 0;
	int mismatches = 0;
	// Status levels and pins in one vector; pattern B is the inverse of pattern A
	localparam logic [17:0] A = 18'h2A969;
	localparam logic [17:0] B = 18'h15696;
	row_t rows [21] = '{
		'{A, CODE_PIN_STATE_WORD, 1'b0, 16'h8A96}, '{A, CODE_SHARED_STATUS_BYTE, 1'b0, 16'h00B9},
		'{A, CODE_ECC_INFO_WORD, 1'b0, 16'h0020}, '{B, CODE_PIN_STATE_WORD, 1'b0, 16'h4569},
		'{B, CODE_SHARED_STATUS_BYTE, 1'b0, 16'h0041}, '{A, 8'h88, 1'b0, 16'hD8C8},
		'{A, 8'h8B, 1'b1, 16'h1234}, '{A, 8'h8B, 1'b0, 16'h0010}, '{A, 8'h89, 1'b0, 16'hE028},
		'{A, 8'hED, 1'b0, 16'hE015}, '{A, 8'hED, 1'b1, 16'hE013}, '{A, 8'h8C, 1'b0, 16'hE020},
		'{A, 8'h8D, 1'b1, 16'hF064}, '{A, 8'h8E, 1'b0, 16'hF03C}, '{A, 8'h94, 1'b0, 16'hF0C8},
		'{A, 8'h96, 1'b0, 16'hF020}, '{A, 8'hDD, 1'b1, 16'h1234}, '{A, 8'hDE, 1'b0, 16'hD8C8},
		'{A, 8'hDF, 1'b0, 16'hF064}, '{A, 8'hF4, 1'b0, 16'hF03C}, '{A, 8'hD7, 1'b0, 16'hE020}};

	assign {supply_3v3_ov, supply_3v3_uv, adc_invalid, alert_drive_low, chan1_pgood, chan0_pgood,
		run_drive_low, gp_drive_low, chan1_run_pin, chan0_run_pin, gp_pin1, gp_pin0, busy,
		calc_pending, in_transition, nvm_initialized} = lv;
	assign {restore_done, reset_cmd_done, bulk_read_done} = ev;

	pmbus_status_telemetry_regs dut (.clock, .rst, .cmd_read, .cmd_write, .cmd_code, .page,
		.clear_maxima_cmd, .rd_data, .rd_valid, .rd_unsupported, .wr_refused, .meas_valid,
		.vin_mant, .vout_mant, .vout_exp, .current_sense_inputs, .diode_raw, .die_temp_mant,
		.duty_frac, .current_sense_gain, .sense_gain_tempco, .ext_temp_gain, .ext_temp_offset,
		.input_current_offset, .supply_3v3_ov, .supply_3v3_uv, .adc_invalid, .alert_drive_low,
		.chan1_pgood, .chan0_pgood, .run_drive_low, .gp_drive_low, .busy, .calc_pending,
		.in_transition, .nvm_initialized, .ecc_corrected, .restore_done, .reset_cmd_done,
		.bulk_read_done, .chan1_run_pin, .chan0_run_pin, .gp_pin1, .gp_pin0,
		.write_protect_pin, .shared_sync_clock);

	telemetry_host_model host (.clock, .cmd_read, .cmd_write, .cmd_code, .page,
		.clear_maxima_cmd, .rd_data, .rd_valid, .rd_unsupported, .wr_refused);

	// Main clock, 25 MHz
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Shared clock from the far side, 320 ns period, offset so edges never meet ours
	initial begin
		shared_sync_clock = 1'b0;
		#7;
		forever #160 if (share_run) shared_sync_clock = ~shared_sync_clock;
	end

	task check(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch at %0t: seen %h want %h", $time, seen, want);
		end
	endtask : check

	task rd(input logic [7:0] c, input logic pg, input logic [15:0] e);
		host.read_word(c, pg, dw, v, u);
		check(dw, e);
	endtask : rd

	// One measurement strobe; only vin and channel 1 vout change between samples
	task sample(input logic [10:0] vi, input logic [15:0] vo);
		@(posedge clock) #1;
		vin_mant = vi;
		vout_mant[1] = vo;
		meas_valid = 1'b1;
		@(posedge clock) #1;
		meas_valid = 1'b0;
	endtask : sample

	task pulse_ev(input logic [2:0] m);
		@(posedge clock) #1;
		ev = m;
		@(posedge clock) #1;
		ev = 3'h0;
	endtask : pulse_ev

	task end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Watchdog well beyond the expected run of about 1900 cycles
	initial begin
		#400000;
		mismatches++;
		end_of_test();
	end

	// Main sequence: reset, table of reads, then maxima, refusals, refresh events, timeout
	initial begin
		rst = 1'b1;
		lv = A;
		ev = 3'h0;
		share_run = 1'b1;
		meas_valid = 1'b0;
		ecc_corrected = 1'b0;
		write_protect_pin = 1'b1;
		vin_mant = 11'h000;
		vout_mant = {16'h0000, 16'h0010};
		vout_exp = 5'h1E;
		current_sense_inputs = {2{12'h020}};
		diode_raw = {2{12'h064}};
		die_temp_mant = 11'h03C;
		duty_frac = {2{10'h200}};
		current_sense_gain = {2{16'h0100}};
		sense_gain_tempco = {2{12'h010}};
		ext_temp_gain = {2{16'h0100}};
		ext_temp_offset = {2{11'h000}};
		input_current_offset = {11'h003, 11'h005};
		repeat (6) @(posedge clock);
		#1 rst = 1'b0;
		sample(11'h0C8, 16'h1234);
		foreach (rows[i]) begin
			lv = rows[i].lv;
			repeat (5) @(posedge clock);
			host.read_word(rows[i].code, rows[i].pg, dw, v, u);
			check(dw, rows[i].exp);
			check({15'h0000, v}, 16'h0001);
		end
		sample(11'h064, 16'h1000);
		rd(8'h88, 1'b0, 16'hD864);
		rd(8'hDE, 1'b0, 16'hD8C8);
		rd(8'hDD, 1'b1, 16'h1234);
		host.pulse_clear();
		rd(8'hDE, 1'b0, 16'hDC00);
		rd(8'hDD, 1'b1, 16'h0000);
		fork
			host.pulse_clear();
			sample(11'h064, 16'h1000);
		join
		rd(8'hDE, 1'b0, 16'hD864);
		host.write_word(8'h88, r);
		check({15'h0000, r}, 16'h0001);
		rd(8'h88, 1'b0, 16'hD864);
		host.read_word(8'h00, 1'b0, dw, v, u);
		check({u, dw[14:0]}, 16'h8000);
		// Correction bit moves only on a refresh event
		ecc_corrected = 1'b1;
		rd(CODE_ECC_INFO_WORD, 1'b0, 16'h0020);
		pulse_ev(3'h4);
		rd(CODE_ECC_INFO_WORD, 1'b0, 16'h0000);
		ecc_corrected = 1'b0;
		pulse_ev(3'h2);
		rd(CODE_ECC_INFO_WORD, 1'b0, 16'h0020);
		ecc_corrected = 1'b1;
		pulse_ev(3'h1);
		rd(CODE_ECC_INFO_WORD, 1'b0, 16'h0000);
		// Shared clock stalls past the timeout, then runs again
		share_run = 1'b0;
		repeat (1700) @(posedge clock);
		rd(CODE_SHARED_STATUS_BYTE, 1'b0, 16'h00BB);
		share_run = 1'b1;
		repeat (20) @(posedge clock);
		rd(CODE_SHARED_STATUS_BYTE, 1'b0, 16'h00B9);
		// Second reset in mid-run with corrections reported
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1 rst = 1'b0;
		rd(CODE_ECC_INFO_WORD, 1'b0, 16'h0000);
		rd(8'hDE, 1'b0, 16'hDC00);
		end_of_test();
	end
endmodule : pmbus_status_telemetry_regs_tb_top
